// file: core/tmr_defs.svh
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define TMR_OFF_MAIN_CTL 5'h00
`define TMR_OFF_STATUS 5'h04
`define TMR_OFF_TRIG_CTL 5'h08
`define TMR_OFF_COUNTER 5'h0c
`define TMR_OFF_CONST_A 5'h10
`define TMR_OFF_CONST_B 5'h14
`define TMR_OFF_IRQ_STATUS 5'h18
`define TMR_OFF_IRQ_MASK 5'h1c

// ****************************************************************
// Field positions
// ****************************************************************
`define TMR_FLAG_HI 7
`define TMR_FLAG_LO 5
`define TMR_OS_B_HI 3
`define TMR_OS_B_LO 2
`define TMR_OS_A_HI 1
`define TMR_OS_A_LO 0
`define TMR_TRIG_EDGE_HI 4
`define TMR_TRIG_EDGE_LO 3
`define TMR_TRIG_START_EN 2
`define TMR_EXTRA_CKS 0
`define TMR_IRQ_EN_HI 7
`define TMR_IRQ_EN_LO 5
`define TMR_CLR_HI 4
`define TMR_CLR_LO 3
`define TMR_CKS_HI 2
`define TMR_CKS_LO 0

// ****************************************************************
// Reset values, reserved ones and writable masks
// ****************************************************************
`define TMR_RST_CONST 8'hff
`define TMR_RST_ZERO 8'h00
`define TMR_STATUS_ONES 8'h10
`define TMR_TRIG_ONES 8'he2
`define TMR_TRIG_WMASK 8'h1d
`define TMR_COUNT_MAX 8'hff

// ****************************************************************
// Encodings
// ****************************************************************
`define TMR_ACT_NONE 2'b00
`define TMR_ACT_LOW 2'b01
`define TMR_ACT_HIGH 2'b10
`define TMR_ACT_TOGGLE 2'b11
`define TMR_EDGE_OFF 2'b00
`define TMR_EDGE_RISE 2'b01
`define TMR_EDGE_FALL 2'b10
`define TMR_EDGE_BOTH 2'b11
`define TMR_CLR_NONE 2'b00
`define TMR_CLR_MATCH_A 2'b01
`define TMR_CLR_MATCH_B 2'b10
`define TMR_CLR_PIN 2'b11
`define TMR_RESP_OKAY 2'b00
`define TMR_RESP_SLVERR 2'b10

`endif

// file: core/tmr_pkg.sv
package tmr_pkg;

    // Timer state carried as one record
    typedef struct packed {
        logic [6:0] presc;
        logic tap_prev;
        logic [7:0] counter;
        logic [7:0] const_a;
        logic [7:0] const_b;
        logic [7:0] main_ctl;
        logic [2:0] flags;
        logic [3:0] out_sel;
        logic [7:0] trig_ctl;
        logic [2:0] armed;
        logic running;
        logic wave;
        logic [1:0] trig_sync;
        logic trig_prev;
        logic [1:0] rpin_sync;
        logic rpin_prev;
        logic [2:0] irq_status;
        logic [2:0] irq_mask;
        logic irq;
        logic irq_req;
    } timer_state_t;

    // Bus slave state: handshake outputs, held write address and data, read data
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [4:0] awaddr;
        logic [31:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } bus_state_t;

endpackage

// file: core/timer_status_output_trigger_ctrl.sv
// Notes on behaviour
// - Match-B flag (status bit 7) sets when counter equals constant B.
// - Match-A flag (status bit 6) sets when counter equals constant A.
// - Wrap flag (status bit 5) sets when counter rolls from max to zero.
// - Flags clear by reading one, then writing zero.
// - Reserved bits read as one: status bit 4, trigger bits 7..5 and 1.
// - Status bits 3:2 pick waveform action on match B.
// - Status bits 1:0 pick waveform action on match A.
// - Match A and match B actions are independent.
// - Waveform output is low after reset until first match.
// - Trigger bits 4:3 select off, rising, falling or both edges.
// - With trigger start on, a clear halts counting; selected edge restarts it.
// - With trigger start off, edges are ignored and counting continues.
// - Trigger bit 0 is an extra clock-select bit.
// - Counter steps on falling edge of clock divided by 4..128.
// - Eight-bit up-counter cleared by match A, match B or reset pin rise.
// - Simultaneous conflicting actions: toggle beats high beats low.
// - Each flag requests an interrupt while its enable bit is set.
`include "tmr_defs.svh"

module timer_status_output_trigger_ctrl
    import tmr_pkg::*;
#(
    parameter int PRE_W = 7
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // AXI4-Lite write address and data
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [4:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // AXI4-Lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // AXI4-Lite read
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [4:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // Pins
    input wire logic i_trigger_in_pin,
    input wire logic i_counter_reset_pin,
    output logic o_waveform_out_pin,
    // Interrupts
    output logic o_irq,
    output logic o_irq_req
);

    // ****************************************************************
    // State
    // ****************************************************************
    timer_state_t st;
    timer_state_t next_st;
    bus_state_t bus;
    bus_state_t next_bus;

    logic wr_go;
    logic [4:0] wr_addr;
    logic rd_go;
    logic [4:0] rd_addr;

    // Mapped address check, low two bits ignored
    function automatic logic mapped(input logic [4:0] a);
        logic [4:0] w;
        w = {a[4:2], 2'b00};
        mapped = (w == `TMR_OFF_MAIN_CTL) || (w == `TMR_OFF_STATUS) ||
                 (w == `TMR_OFF_TRIG_CTL) || (w == `TMR_OFF_COUNTER) ||
                 (w == `TMR_OFF_CONST_A) || (w == `TMR_OFF_CONST_B) ||
                 (w == `TMR_OFF_IRQ_STATUS) || (w == `TMR_OFF_IRQ_MASK);
    endfunction

    // Read mux with reserved ones forced in
    function automatic logic [7:0] read_reg(input logic [4:0] a, input timer_state_t s);
        logic [7:0] v;
        v = 8'h00;
        case ({a[4:2], 2'b00})
            `TMR_OFF_MAIN_CTL: v = s.main_ctl;
            `TMR_OFF_STATUS: v = {s.flags, 1'b0, s.out_sel} | `TMR_STATUS_ONES;
            `TMR_OFF_TRIG_CTL: v = s.trig_ctl | `TMR_TRIG_ONES;
            `TMR_OFF_COUNTER: v = s.counter;
            `TMR_OFF_CONST_A: v = s.const_a;
            `TMR_OFF_CONST_B: v = s.const_b;
            `TMR_OFF_IRQ_STATUS: v = {s.irq_status, 5'h00};
            `TMR_OFF_IRQ_MASK: v = {s.irq_mask, 5'h00};
            default: v = 8'h00;
        endcase
        read_reg = v;
    endfunction

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    // Address and data latch independently; write fires once both are held
    always_comb begin
        next_bus = bus;
        wr_go = 1'b0;
        wr_addr = bus.awaddr;
        rd_go = 1'b0;
        rd_addr = i_araddr;
        if (i_awvalid && bus.awready) begin
            next_bus.aw_held = 1'b1;
            next_bus.awready = 1'b0;
            next_bus.awaddr = i_awaddr;
        end
        if (i_wvalid && bus.wready) begin
            next_bus.w_held = 1'b1;
            next_bus.wready = 1'b0;
            next_bus.wdata = i_wdata;
            next_bus.wstrb0 = i_wstrb[0];
        end
        if (bus.aw_held && bus.w_held && !bus.bvalid) begin
            wr_go = mapped(bus.awaddr) && bus.wstrb0;
            next_bus.bvalid = 1'b1;
            next_bus.bresp = mapped(bus.awaddr) ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
            next_bus.aw_held = 1'b0;
            next_bus.w_held = 1'b0;
        end
        if (bus.bvalid && i_bready) begin
            next_bus.bvalid = 1'b0;
            next_bus.awready = 1'b1;
            next_bus.wready = 1'b1;
        end
        // One read at a time; reads with side effects fire once
        if (i_arvalid && bus.arready) begin
            rd_go = mapped(i_araddr);
            next_bus.arready = 1'b0;
            next_bus.rvalid = 1'b1;
            next_bus.rdata = {24'h000000, read_reg(i_araddr, st)};
            next_bus.rresp = mapped(i_araddr) ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
        end
        if (bus.rvalid && i_rready) begin
            next_bus.rvalid = 1'b0;
            next_bus.arready = 1'b1;
        end
    end

    // Bus registers
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bus <= '0;
            bus.awready <= 1'b1;
            bus.wready <= 1'b1;
            bus.arready <= 1'b1;
        end else begin
            bus <= next_bus;
        end
    end

    // ****************************************************************
    // Timer core
    // ****************************************************************
    logic [2:0] cks;
    logic [2:0] tap_idx;
    logic tap_on;
    logic tap;
    logic tick;
    logic step;
    logic match_a;
    logic match_b;
    logic wrap;
    logic rpin_rise;
    logic trig_rise;
    logic trig_fall;
    logic trig_edge;
    logic clear_evt;
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic any_toggle;
    logic any_high;
    logic any_low;
    logic [2:0] set_evt;
    logic [7:0] wd;

    // Counting, matching, flags, waveform and interrupts
    always_comb begin
        next_st = st;
        wd = bus.wdata[7:0];
        cks = st.main_ctl[`TMR_CKS_HI:`TMR_CKS_LO];
        // Divider tap: extra select takes the larger divisor of each pair
        tap_on = 1'b1;
        case (cks)
            3'b001: tap_idx = st.trig_ctl[`TMR_EXTRA_CKS] ? 3'd2 : 3'd1;
            3'b010: tap_idx = st.trig_ctl[`TMR_EXTRA_CKS] ? 3'd4 : 3'd3;
            3'b011: tap_idx = st.trig_ctl[`TMR_EXTRA_CKS] ? 3'd6 : 3'd5;
            default: begin
                tap_idx = 3'd0;
                tap_on = 1'b0;
            end
        endcase
        // Source switches can look like a falling edge, as on the original part
        tap = tap_on && st.presc[tap_idx];
        tick = st.tap_prev && !tap;
        step = tick && st.running;
        next_st.presc = st.presc + 7'd1;
        next_st.tap_prev = tap;
        // Compare in the last state of equality; a constant write inhibits it
        match_a = step && (st.counter == st.const_a) &&
                  !(wr_go && {wr_addr[4:2], 2'b00} == `TMR_OFF_CONST_A);
        match_b = step && (st.counter == st.const_b) &&
                  !(wr_go && {wr_addr[4:2], 2'b00} == `TMR_OFF_CONST_B);
        wrap = step && (st.counter == `TMR_COUNT_MAX);
        // Two-flop synchronisers, edges seen off the second stage
        next_st.trig_sync = {st.trig_sync[0], i_trigger_in_pin};
        next_st.trig_prev = st.trig_sync[1];
        next_st.rpin_sync = {st.rpin_sync[0], i_counter_reset_pin};
        next_st.rpin_prev = st.rpin_sync[1];
        trig_rise = st.trig_sync[1] && !st.trig_prev;
        trig_fall = !st.trig_sync[1] && st.trig_prev;
        rpin_rise = st.rpin_sync[1] && !st.rpin_prev;
        case (st.trig_ctl[`TMR_TRIG_EDGE_HI:`TMR_TRIG_EDGE_LO])
            `TMR_EDGE_RISE: trig_edge = trig_rise;
            `TMR_EDGE_FALL: trig_edge = trig_fall;
            `TMR_EDGE_BOTH: trig_edge = trig_rise || trig_fall;
            default: trig_edge = 1'b0;
        endcase
        case (st.main_ctl[`TMR_CLR_HI:`TMR_CLR_LO])
            `TMR_CLR_MATCH_A: clear_evt = match_a;
            `TMR_CLR_MATCH_B: clear_evt = match_b;
            `TMR_CLR_PIN: clear_evt = rpin_rise;
            default: clear_evt = 1'b0;
        endcase
        // Clear beats a counter write; a write beats a step
        if (clear_evt) begin
            next_st.counter = `TMR_RST_ZERO;
        end else if (wr_go && {wr_addr[4:2], 2'b00} == `TMR_OFF_COUNTER) begin
            next_st.counter = wd;
        end else if (step) begin
            next_st.counter = st.counter + 8'd1;
        end
        // Start/stop under trigger control
        if (!st.trig_ctl[`TMR_TRIG_START_EN]) begin
            next_st.running = 1'b1;
        end else if (clear_evt) begin
            next_st.running = 1'b0;
        end else if (trig_edge) begin
            next_st.running = 1'b1;
        end
        // Waveform: each match has its own action field
        act_a = match_a ? st.out_sel[`TMR_OS_A_HI:`TMR_OS_A_LO] : `TMR_ACT_NONE;
        act_b = match_b ? st.out_sel[`TMR_OS_B_HI:`TMR_OS_B_LO] : `TMR_ACT_NONE;
        any_toggle = (act_a == `TMR_ACT_TOGGLE) || (act_b == `TMR_ACT_TOGGLE);
        any_high = (act_a == `TMR_ACT_HIGH) || (act_b == `TMR_ACT_HIGH);
        any_low = (act_a == `TMR_ACT_LOW) || (act_b == `TMR_ACT_LOW);
        if (any_toggle) begin
            next_st.wave = !st.wave;
        end else if (any_high) begin
            next_st.wave = 1'b1;
        end else if (any_low) begin
            next_st.wave = 1'b0;
        end
        // Register writes other than the counter
        if (wr_go) begin
            case ({wr_addr[4:2], 2'b00})
                `TMR_OFF_MAIN_CTL: next_st.main_ctl = wd;
                `TMR_OFF_STATUS: begin
                    next_st.out_sel = wd[`TMR_OS_B_HI:`TMR_OS_A_LO];
                    // Zero clears only an armed flag; one is ignored
                    next_st.flags = st.flags &
                        ~(st.armed & ~wd[`TMR_FLAG_HI:`TMR_FLAG_LO]);
                    next_st.armed = 3'b000;
                end
                `TMR_OFF_TRIG_CTL: next_st.trig_ctl = wd & `TMR_TRIG_WMASK;
                `TMR_OFF_CONST_A: next_st.const_a = wd;
                `TMR_OFF_CONST_B: next_st.const_b = wd;
                `TMR_OFF_IRQ_MASK: next_st.irq_mask = wd[`TMR_FLAG_HI:`TMR_FLAG_LO];
                default: next_st.irq_mask = next_st.irq_mask;
            endcase
        end
        // Reading status arms the flags then set; reading irq status clears it
        if (rd_go && {rd_addr[4:2], 2'b00} == `TMR_OFF_STATUS) begin
            next_st.armed = st.flags;
        end
        if (rd_go && {rd_addr[4:2], 2'b00} == `TMR_OFF_IRQ_STATUS) begin
            next_st.irq_status = 3'b000;
        end
        // New events win over any clear in the same cycle
        set_evt = {match_b, match_a, wrap};
        next_st.flags = next_st.flags | set_evt;
        next_st.irq_status = next_st.irq_status | set_evt;
        next_st.irq_req = |(next_st.flags &
                            next_st.main_ctl[`TMR_IRQ_EN_HI:`TMR_IRQ_EN_LO]);
        next_st.irq = |(next_st.irq_status & next_st.irq_mask);
    end

    // Timer registers
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st <= '0;
            st.const_a <= `TMR_RST_CONST;
            st.const_b <= `TMR_RST_CONST;
            st.running <= 1'b1;
            st.wave <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Outputs, all straight from flops
    // ****************************************************************
    assign o_awready = bus.awready;
    assign o_wready = bus.wready;
    assign o_bvalid = bus.bvalid;
    assign o_bresp = bus.bresp;
    assign o_arready = bus.arready;
    assign o_rvalid = bus.rvalid;
    assign o_rdata = bus.rdata;
    assign o_rresp = bus.rresp;
    assign o_waveform_out_pin = st.wave;
    assign o_irq = st.irq;
    assign o_irq_req = st.irq_req;

endmodule // timer_status_output_trigger_ctrl

// file: dv/tmr_ctrl_monitor.sv
`include "tmr_defs.svh"

module tmr_ctrl_monitor #(
    parameter int PRE_W = 7
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // Bus handshakes
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic [4:0] i_araddr,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic [31:0] o_rdata,
    // Waveform pin
    input wire logic o_waveform_out_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    logic [4:0] rd_addr;
    logic [4:0] next_rd_addr;

    // Remember which register the pending read targets
    always_comb begin
        next_rd_addr = rd_addr;
        if (i_arvalid && o_arready) next_rd_addr = i_araddr;
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) rd_addr <= 5'h00;
        else rd_addr <= next_rd_addr;
    end

    // ****************
    // Bus steps
    // ****************
    sequence s_aw_take; i_awvalid && o_awready; endsequence
    sequence s_w_take; i_wvalid && o_wready; endsequence
    sequence s_r_wait; o_rvalid && !i_rready; endsequence

    // Both halves taken on one edge: held next edge, response the edge after
    a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready
        |-> ##2 o_bvalid)
        else $error("write response late");
    a_w_blocked: assert property (s_w_take |=> !o_wready)
        else $error("second write data accepted");
    a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
        else $error("write response dropped");
    a_aw_blocked: assert property (s_aw_take |=> !o_awready)
        else $error("second write address accepted");
    a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read data late");
    a_ar_blocked: assert property (i_arvalid && o_arready |=> !o_arready)
        else $error("second read accepted");
    a_read_hold: assert property (s_r_wait |=> o_rvalid && $stable(o_rdata))
        else $error("read data not held");
    a_upper_zero: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_status_ones: assert property (o_rvalid && rd_addr == `TMR_OFF_STATUS |-> o_rdata[4])
        else $error("status spare bit low");
    a_trig_ones: assert property (o_rvalid && rd_addr == `TMR_OFF_TRIG_CTL
        |-> o_rdata[7:5] == 3'b111 && o_rdata[1])
        else $error("trigger spare bits low");
    // Nothing can tick in the first cycles after reset, so the pin must stay low
    a_wave_reset: assert property (!$past(i_rst_b) |-> !o_waveform_out_pin [*2])
        else $error("waveform high after reset");
endmodule // tmr_ctrl_monitor

bind timer_status_output_trigger_ctrl tmr_ctrl_monitor #(.PRE_W(PRE_W)) tmr_ctrl_monitor_inst (
    .i_mclk, .i_rst_b, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bvalid, .i_bready,
    .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_waveform_out_pin
);

// file: dv/pin_partner.sv
module pin_partner (
    // Clock and bench commands
    input wire logic i_mclk,
    input wire logic i_trig_level,
    input wire logic i_pulse_req,
    // Pins towards the timer
    output logic o_trigger_in_pin = 1'b0,
    output logic o_counter_reset_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] hold = 2'h0;

    // Clear pulse lasts 3 cycles, above the 1.5-clock minimum width
    always @(posedge i_mclk) begin
        if (i_pulse_req) hold <= 2'h3;
        else if (hold != 2'h0) hold <= hold - 2'h1;
        o_trigger_in_pin <= i_trig_level;
    end

    assign o_counter_reset_pin = (hold != 2'h0);
endmodule // pin_partner

// file: dv/testbench.sv
`include "tmr_defs.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst_b, awvalid, wvalid, bready, arvalid, rready, trig_lvl, pulse_req;
    logic [4:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid, trig_pin, rpin, wave, irq, irq_req;
    logic [1:0] bresp, rresp;
    int n_errors = 0;
    int compares = 0;

    timer_status_output_trigger_ctrl #(.PRE_W(7)) timer_status_output_trigger_ctrl_inst (
        .i_mclk(mclk), .i_rst_b(rst_b), .i_awvalid(awvalid), .o_awready(awready),
        .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
        .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
        .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
        .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_trigger_in_pin(trig_pin),
        .i_counter_reset_pin(rpin), .o_waveform_out_pin(wave), .o_irq(irq),
        .o_irq_req(irq_req));
    pin_partner pin_partner_inst (.i_mclk(mclk), .i_trig_level(trig_lvl),
        .i_pulse_req(pulse_req), .o_trigger_in_pin(trig_pin), .o_counter_reset_pin(rpin));

    // ****************
    // Common tasks
    // ****************
    task automatic end_sim;
        $display("errors %0d of %0d compares", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Bus tasks sample at the falling edge so the rising edge stays race free
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic ta, tw, tb;
        logic [1:0] rs;
        int n;
        @(posedge mclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= {24'h0, d};
        wstrb <= 4'hf;
        bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge mclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            rs = bresp;
            @(posedge mclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) break;
        end
        bready <= 1'b0;
        check(32'(rs), 32'(`TMR_RESP_OKAY));
        if (n == 40) check(32'h0, 32'h1);
        if (n == 40) end_sim();
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        logic ta, tv;
        logic [1:0] rs;
        int n;
        @(posedge mclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge mclk);
            ta = arvalid && arready;
            tv = rvalid;
            d = rdata[7:0];
            rs = rresp;
            @(posedge mclk);
            if (ta) arvalid <= 1'b0;
            if (tv) break;
        end
        rready <= 1'b0;
        check(32'(rs), 32'(`TMR_RESP_OKAY));
        if (n == 40) check(32'h0, 32'h1);
        if (n == 40) end_sim();
    endtask

    // Pin picks: 0 waveform, 1 interrupt, 2 enabled request
    task automatic wait_for(input logic [1:0] sel, input logic v);
        logic s;
        int n;
        for (n = 0; n < 300; n++) begin
            @(negedge mclk);
            s = (sel == 2'd0) ? wave : (sel == 2'd1) ? irq : irq_req;
            if (s === v) break;
        end
        check(32'(s), 32'(v));
        @(posedge mclk);
        if (n == 300) end_sim();
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_reset;
        logic [7:0] d;
        logic [7:0] exp [8] = '{8'h00, 8'h10, 8'he2, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00};
        for (int i = 0; i < 8; i++) begin
            rd(5'(i * 4), d);
            check(32'(d), 32'(exp[i]));
        end
        wait_for(2'd0, 1'b0);
        $display("done reset values");
    endtask

    task automatic t_reserved;
        logic [7:0] d;
        wr(`TMR_OFF_STATUS, 8'hff);
        rd(`TMR_OFF_STATUS, d);
        check(32'(d), 32'h1f);
        wr(`TMR_OFF_TRIG_CTL, 8'hff);
        rd(`TMR_OFF_TRIG_CTL, d);
        check(32'(d), 32'hff);
        wr(`TMR_OFF_TRIG_CTL, 8'h00);
        wr(`TMR_OFF_STATUS, 8'h00);
        rd(`TMR_OFF_TRIG_CTL, d);
        check(32'(d), 32'he2);
        $display("done reserved bits");
    endtask

    // High on A, low on B, counter cleared by B
    task automatic t_match;
        logic [7:0] d;
        wr(`TMR_OFF_CONST_A, 8'h05);
        wr(`TMR_OFF_CONST_B, 8'h0a);
        wr(`TMR_OFF_STATUS, 8'h06);
        wr(`TMR_OFF_MAIN_CTL, 8'h11);
        wait_for(2'd0, 1'b1);
        wait_for(2'd0, 1'b0);
        wr(`TMR_OFF_MAIN_CTL, 8'h10);
        rd(`TMR_OFF_STATUS, d);
        check(32'(d), 32'hd6);
        wr(`TMR_OFF_STATUS, 8'hd6);
        wr(`TMR_OFF_STATUS, 8'h46);
        rd(`TMR_OFF_STATUS, d);
        check(32'(d), 32'hd6);
        wr(`TMR_OFF_STATUS, 8'h46);
        rd(`TMR_OFF_STATUS, d);
        check(32'(d), 32'h56);
        $display("done compare match");
    endtask

    // Same-cycle matches: low on A loses to toggle on B
    task automatic t_toggle;
        wr(`TMR_OFF_CONST_A, 8'h03);
        wr(`TMR_OFF_CONST_B, 8'h03);
        wr(`TMR_OFF_STATUS, 8'h0d);
        wr(`TMR_OFF_MAIN_CTL, 8'h09);
        wait_for(2'd0, 1'b1);
        wait_for(2'd0, 1'b0);
        wait_for(2'd0, 1'b1);
        wr(`TMR_OFF_MAIN_CTL, 8'h00);
        $display("done toggle priority");
    endtask

    task automatic t_wrap;
        logic [7:0] d;
        wr(`TMR_OFF_CONST_A, 8'hff);
        wr(`TMR_OFF_CONST_B, 8'hff);
        wr(`TMR_OFF_COUNTER, 8'hfc);
        wr(`TMR_OFF_STATUS, 8'h00);
        wr(`TMR_OFF_IRQ_MASK, 8'h20);
        wr(`TMR_OFF_MAIN_CTL, 8'h21);
        wait_for(2'd1, 1'b1);
        wr(`TMR_OFF_MAIN_CTL, 8'h20);
        wait_for(2'd2, 1'b1);
        rd(`TMR_OFF_STATUS, d);
        check(32'(d), 32'hf0);
        wr(`TMR_OFF_IRQ_MASK, 8'h00);
        wait_for(2'd1, 1'b0);
        rd(`TMR_OFF_IRQ_STATUS, d);
        check(32'(d), 32'he0);
        wr(`TMR_OFF_IRQ_MASK, 8'h20);
        wait_for(2'd1, 1'b0);
        wr(`TMR_OFF_STATUS, 8'h00);
        rd(`TMR_OFF_STATUS, d);
        check(32'(d), 32'h10);
        wait_for(2'd2, 1'b0);
        $display("done wrap and interrupt");
    endtask

    // Every edge code and direction, then trigger start off
    task automatic t_trigger;
        logic [7:0] c;
        logic [1:0] e;
        logic en, dir, run;
        wr(`TMR_OFF_MAIN_CTL, 8'h19);
        for (int i = 0; i < 9; i++) begin
            en = (i < 8);
            e = 2'(i >> 1);
            dir = i[0];
            run = !en || e == 2'b11 || (e == 2'b01 && dir) || (e == 2'b10 && !dir);
            wr(`TMR_OFF_TRIG_CTL, {3'h0, e, en, 2'h0});
            trig_lvl <= !dir;
            cyc(8);
            pulse_req <= 1'b1;
            cyc(1);
            pulse_req <= 1'b0;
            cyc(12);
            rd(`TMR_OFF_COUNTER, c);
            check(32'(c != 8'h00), 32'(!en));
            trig_lvl <= dir;
            cyc(24);
            rd(`TMR_OFF_COUNTER, c);
            check(32'(c != 8'h00), 32'(run));
        end
        $display("done trigger start");
    endtask

    // Eight ticks at each divisor from 4 to 128
    task automatic t_divide;
        logic [7:0] c;
        for (int k = 0; k < 6; k++) begin
            wr(`TMR_OFF_TRIG_CTL, 8'(k % 2));
            wr(`TMR_OFF_MAIN_CTL, 8'(k / 2 + 1));
            wr(`TMR_OFF_COUNTER, 8'h00);
            cyc(32 << k);
            rd(`TMR_OFF_COUNTER, c);
            check(32'(c >= 8'h07 && c <= 8'h09), 32'h1);
        end
        $display("done clock divide");
    endtask

    // Free-running clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Main sequence
    initial begin
        {rst_b, awvalid, wvalid, bready, arvalid, rready, trig_lvl, pulse_req} = 8'h00;
        {awaddr, araddr, wstrb} = 14'h0000;
        wdata = 32'h0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset();
        t_reserved();
        t_match();
        t_toggle();
        t_wrap();
        t_trigger();
        t_divide();
        end_sim();
    end
endmodule // testbench
